// ### hdl/ccr_pkg.sv
//==============================================================================
// Charger control register bank: shared constants and types
package ccr_pkg;

  //============================================================================
  // Register command codes
  localparam logic [7:0] OFS_CTRL_SEVEN = 8'h38; // Second-level limit timing
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h3c; // Monitor and threshold
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h3d; // Alarm timing, comparator
  localparam logic [7:0] OFS_CTRL_THREE = 8'h4c; // Charging options, reset
  localparam logic [7:0] OFS_CTRL_FOUR  = 8'h4e; // Alarm triggers, latch

  //============================================================================
  // Reset values
  localparam logic [15:0] RST_CTRL_SEVEN = 16'h0000; // All fields zero
  localparam logic [15:0] RST_CTRL_ONE   = 16'h0003; // Threshold code 011
  localparam logic [15:0] RST_CTRL_TWO   = 16'h6000; // Trickle code 011
  localparam logic [15:0] RST_CTRL_THREE = 16'h0300; // Power monitor gain 11
  localparam logic [15:0] RST_CTRL_FOUR  = 16'h0000; // All triggers off

  //============================================================================
  // Field positions
  localparam int C1_MON_SEL    = 4;  // Current monitor select
  localparam int C1_VLO_LSB    = 0;  // Low system voltage code, 3 bits
  localparam int C2_TRKL_LSB   = 13; // Trickle current code, 3 bits
  localparam int C2_TWO_LVL    = 12; // Two-level limit enable
  localparam int C2_FLT_DEB    = 11; // Fault debounce select
  localparam int C2_ADEB_LSB   = 9;  // Alarm debounce code, 2 bits
  localparam int C2_DUR_LSB    = 6;  // Alarm minimum duration, 3 bits
  localparam int C2_PROF_HI    = 5;  // Thermistor profile upper bit
  localparam int C2_CMP_DIS    = 3;  // Comparator off, pin to interrupt
  localparam int C2_CMP_POL    = 2;  // Comparator polarity invert
  localparam int C3_NO_RELOAD  = 14; // Suppress limit reload
  localparam int C3_TERM_LONG  = 13; // Long termination time
  localparam int C3_TMO_LSB    = 11; // Bus timeout code, 2 bits
  localparam int C3_AUTO_CHG   = 7;  // Autonomous charging enable
  localparam int C3_DIG_RST    = 2;  // Digital reset strobe
  localparam int C3_ADC_ALL    = 0;  // ADC in all modes
  localparam int C4_ABS_IGN    = 15; // Ignore battery-absent input
  localparam int C4_PROF_LO    = 14; // Thermistor profile lower bit
  localparam int C4_EN_OVC     = 7;  // Trigger: reverse overcurrent
  localparam int C4_EN_BAT     = 6;  // Trigger: battery removal
  localparam int C4_EN_ADP     = 5;  // Trigger: adapter loss
  localparam int C4_EN_CMP     = 4;  // Trigger: comparator rising
  localparam int C4_EDEB_LSB   = 2;  // Edge debounce code, 2 bits
  localparam int C4_CLR        = 1;  // Alarm clear strobe
  localparam int C4_LATCH      = 0;  // Alarm latch mode
  localparam int C7_T2_LSB     = 13; // Second-level time code, 3 bits
  localparam int C7_T1_LSB     = 10; // First-level time code, 3 bits
  localparam int C7_EOC_LSB    = 8;  // End-of-charge current code, 2 bits

  //============================================================================
  // Timing: all long delays count microsecond ticks
  localparam int CLK_PERIOD_NS = 10;   // 100 MHz reference clock
  localparam int US_NS         = 1000; // One microsecond
  localparam int TICK_CYC      = US_NS / CLK_PERIOD_NS; // Cycles per tick
  localparam int DEB_SUP_US    = 2;       // Fixed low-voltage debounce
  localparam int FLT_LONG_US   = 1300000; // 1.3 s fault debounce
  localparam int FLT_SHORT_US  = 150000;  // 150 ms fault debounce
  localparam int CNT_W         = 21;      // Holds the longest debounce
  localparam int DUR_W         = 15;      // Holds 20000 us

  //============================================================================
  // Configuration handed to the analog and control logic
  typedef struct packed {
    logic        mon_battery;   // 1: battery monitor drives shared pin
    logic [2:0]  vsys_lo_code;  // Low system voltage threshold code
    logic [2:0]  trickle_code;  // Trickle current code
    logic [1:0]  therm_profile; // Thermistor profile, 00 = ADC input
    logic        therm_src_on;  // Thermistor current source on
    logic [1:0]  timeout_code;  // Bus inactivity timeout code
    logic        term_long;     // Termination time 200 ms
    logic        auto_charge;   // Autonomous charging active
    logic [1:0]  eoc_code;      // End-of-charge current code
    logic        two_level;     // Two-level limit enabled
    logic [14:0] t1_us;         // First-level time in us
    logic [13:0] t2_us;         // Second-level time in us
  } ccr_cfg_type;

endpackage

// ### hdl/ccr_bank.sv
`timescale 1ns/10ps
//==============================================================================
// Charger control register bank with alarm output logic
module ccr_bank #(
  parameter int TICK_CYC = ccr_pkg::TICK_CYC // Cycles per microsecond tick
) (
  input  wire logic        ref_clk_in,        // 100 MHz clock
  input  wire logic        rst_b_in,          // Async reset, active low
  input  wire logic [7:0]  cmd_in,            // Register command code
  input  wire logic        wr_en_in,          // Write-word strobe
  input  wire logic [15:0] wr_data_in,        // Write-word data
  input  wire logic        rd_en_in,          // Read-word strobe
  output logic      [15:0] rd_data_out,       // Read data, next cycle
  input  wire logic        adapter_present_in,  // Adapter attached
  input  wire logic        battery_absent_in,   // Battery missing pin
  input  wire logic        charging_in,         // Charger is charging
  input  wire logic        supplemental_in,     // Supplemental mode on
  input  wire logic        ac_dc_alarm_in,      // Raw current alarms
  input  wire logic        low_vsys_in,         // System below threshold
  input  wire logic        rev_ovc_in,          // Reverse overcurrent
  input  wire logic        cmp_above_in,        // Comparator input > ref
  input  wire logic        overtemp_in,         // Raw die overtemperature
  input  wire logic        overcurrent_in,      // Raw extreme overcurrent
  input  wire logic        charge_timer_exp_in, // 12-hour timer expired
  input  wire logic        other_fault_in,      // Any other charger fault
  input  wire logic        int_req_in,          // Interrupt request
  output logic             alarm_o_out,         // Alarm pin drive value
  output logic             alarm_oe_out,        // Alarm pin pulled low
  output logic             shared_o_out,        // Comparator/int pin value
  output logic             shared_oe_out,       // Comparator/int pin drive
  output logic             fault_out,           // Debounced die fault
  output logic             adc_enable_out,      // ADC running
  output logic             bat_absent_out,      // Battery-absent, used
  output logic             limit_reload_out,    // Reload limit, pulse
  output logic             resample_req_out,    // Resample resistor, pulse
  output ccr_pkg::ccr_cfg_type cfg_out          // Configuration fields
);

  //============================================================================
  // State
  // Everything that holds a value lives in one struct, so reset and the
  // clock edge touch a single variable. Debounce slots by index:
  // 0 current alarm, 1 low system voltage, 2 adapter loss,
  // 3 battery removal, 4 die overtemperature, 5 extreme overcurrent.
  localparam int NSRC = 6; // Debounced sources

  typedef struct packed {
    logic [15:0]                   c7;       // Control word seven
    logic [15:0]                   c1;       // Control word one
    logic [15:0]                   c2;       // Control word two
    logic [15:0]                   c3;       // Control word three
    logic [15:0]                   c4;       // Control word four
    logic [15:0]                   rd_data;  // Read data register
    logic [15:0]                   tick_cnt; // Microsecond divider
    logic                          tick;     // Microsecond tick
    logic [NSRC-1:0][ccr_pkg::CNT_W-1:0] deb_cnt; // Debounce counters
    logic [NSRC-1:0]               deb_ok;   // Debounced levels
    logic [ccr_pkg::DUR_W-1:0]     dur_cnt;  // Minimum hold left, us
    logic                          active;   // Alarm asserted
    logic                          latched;  // Alarm held until cleared
    logic                          adp_prev; // Adapter level last cycle
    logic                          cmp_prev; // Comparator level last cycle
    logic                          reload;   // Reload pulse
    logic                          resample; // Resample pulse
  } ccr_state_type;

  ccr_state_type st_q; // Registered state
  ccr_state_type st_d; // Next state

  //============================================================================
  // Decode helpers
  // Duration table shared by the alarm hold and first-level time
  // The 20 ms entry needs fifteen bits; a narrower table wraps it
  function automatic logic [ccr_pkg::DUR_W-1:0] dur_us(
    input logic [2:0] code);
    case (code)
      3'h0:    dur_us = 15'd10000;
      3'h1:    dur_us = 15'd20000;
      3'h2:    dur_us = 15'd15000;
      3'h3:    dur_us = 15'd5000;
      3'h4:    dur_us = 15'd1000;
      3'h5:    dur_us = 15'd500;
      3'h6:    dur_us = 15'd100;
      default: dur_us = 15'd0;
    endcase
  endfunction

  // Second-level table tops out at 10 ms, which fits fourteen bits
  function automatic logic [13:0] t2_us(input logic [2:0] code);
    case (code)
      3'h0:    t2_us = 14'd10;
      3'h1:    t2_us = 14'd100;
      3'h2:    t2_us = 14'd500;
      3'h3:    t2_us = 14'd1000;
      3'h4:    t2_us = 14'd300;
      3'h5:    t2_us = 14'd750;
      3'h6:    t2_us = 14'd2000;
      default: t2_us = 14'd10000;
    endcase
  endfunction

  function automatic logic [ccr_pkg::CNT_W-1:0] adeb_us(
    input logic [1:0] code);
    case (code)
      2'h0:    adeb_us = 21'd7;
      2'h1:    adeb_us = 21'd100;
      2'h2:    adeb_us = 21'd500;
      default: adeb_us = 21'd1000;
    endcase
  endfunction

  function automatic logic [ccr_pkg::CNT_W-1:0] edeb_us(
    input logic [1:0] code);
    case (code)
      2'h0:    edeb_us = 21'd2;
      2'h1:    edeb_us = 21'd25;
      2'h2:    edeb_us = 21'd125;
      default: edeb_us = 21'd250;
    endcase
  endfunction

  //============================================================================
  // Derived combinational signals
  logic                      bat_abs;   // Battery-absent after ignore
  logic                      cmp_out;   // Comparator after polarity
  logic [NSRC-1:0]           deb_src;   // Raw levels to debounce
  logic [NSRC-1:0][ccr_pkg::CNT_W-1:0] deb_thr; // Thresholds in us
  logic                      trig_lvl;  // Level triggers present
  logic                      trig_evt;  // Edge trigger this cycle
  logic                      flt;       // Debounced die fault

  // Source levels, thresholds and trigger terms for this cycle; the
  // thresholds follow the registers at once, so a rewrite mid-count
  // simply moves the finish line
  always_comb begin
    bat_abs = battery_absent_in & ~st_q.c4[ccr_pkg::C4_ABS_IGN];
    cmp_out = cmp_above_in ^ st_q.c2[ccr_pkg::C2_CMP_POL];
    deb_src = {overcurrent_in, overtemp_in, bat_abs, ~adapter_present_in,
               low_vsys_in, ac_dc_alarm_in};
    deb_thr[0] = adeb_us(st_q.c2[ccr_pkg::C2_ADEB_LSB +: 2]);
    deb_thr[1] = supplemental_in ? ccr_pkg::CNT_W'(ccr_pkg::DEB_SUP_US)
                                 : deb_thr[0];
    deb_thr[2] = edeb_us(st_q.c4[ccr_pkg::C4_EDEB_LSB +: 2]);
    deb_thr[3] = deb_thr[2];
    deb_thr[4] = st_q.c2[ccr_pkg::C2_FLT_DEB] ?
                 ccr_pkg::CNT_W'(ccr_pkg::FLT_SHORT_US) :
                 ccr_pkg::CNT_W'(ccr_pkg::FLT_LONG_US);
    deb_thr[5] = deb_thr[4];
    flt = st_q.deb_ok[4] | st_q.deb_ok[5];
    trig_lvl = st_q.deb_ok[0] | st_q.deb_ok[1]
             | (st_q.c4[ccr_pkg::C4_EN_OVC] & rev_ovc_in)
             | (st_q.c4[ccr_pkg::C4_EN_BAT] & st_q.deb_ok[3])
             | (st_q.c4[ccr_pkg::C4_EN_ADP] & st_q.deb_ok[2]);
    trig_evt = st_q.c4[ccr_pkg::C4_EN_CMP] & cmp_out & ~st_q.cmp_prev;
  end

  //============================================================================
  // Next-state logic
  // Pulses default low and edge detectors follow their pins every cycle;
  // later statements win, so bus writes override hardware clears
  always_comb begin
    st_d          = st_q;
    st_d.reload   = 1'b0;
    st_d.resample = 1'b0;
    st_d.adp_prev = adapter_present_in;
    st_d.cmp_prev = cmp_out;

    // Free-running microsecond tick keeps long counters narrow
    if (st_q.tick_cnt >= 16'(TICK_CYC - 1)) begin
      st_d.tick_cnt = 16'h0000;
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 16'h0001;
      st_d.tick     = 1'b0;
    end

    // Debounce: a level must hold for its whole threshold
    // Counters stop at the threshold instead of wrapping around
    for (int i = 0; i < NSRC; i++) begin
      if (!deb_src[i]) begin
        st_d.deb_cnt[i] = '0;
        st_d.deb_ok[i]  = 1'b0;
      end else if (st_q.deb_cnt[i] >= deb_thr[i]) begin
        st_d.deb_ok[i]  = 1'b1;
      end else if (st_q.tick) begin
        st_d.deb_cnt[i] = st_q.deb_cnt[i] + 21'h000001;
      end
    end

    // Minimum hold counter runs down in microseconds
    // A zero hold (code 111) lets the alarm drop right after it rises
    if (st_q.tick && st_q.dur_cnt != '0) begin
      st_d.dur_cnt = st_q.dur_cnt - 15'h0001;
    end

    // clear strobe drops the latch; a trip below still wins
    if (wr_en_in && cmd_in == ccr_pkg::OFS_CTRL_FOUR &&
        wr_data_in[ccr_pkg::C4_CLR]) begin
      st_d.latched = 1'b0;
    end

    if (trig_lvl || trig_evt) begin
      // New assertion loads the programmed hold time
      if (!st_q.active) begin
        // hold at least the minimum time
        st_d.dur_cnt = ccr_pkg::DUR_W'(
          dur_us(st_q.c2[ccr_pkg::C2_DUR_LSB +: 3]));
      end
      st_d.active = 1'b1;
      if (st_q.c4[ccr_pkg::C4_LATCH]) begin
        st_d.latched = 1'b1;
      end
    end else if (st_q.active && st_q.dur_cnt == '0 && !st_d.latched) begin
      st_d.active = 1'b0;
    end

    if (st_q.adp_prev && !adapter_present_in &&
        !st_q.c3[ccr_pkg::C3_NO_RELOAD]) begin
      st_d.reload = 1'b1;
    end

    // autonomous mode ends on timer expiry or fault
    if (charge_timer_exp_in || other_fault_in || flt) begin
      st_d.c3[ccr_pkg::C3_AUTO_CHG] = 1'b0;
    end

    // Register writes: whole words only
    // word writes by command
    if (wr_en_in) begin
      case (cmd_in)
        ccr_pkg::OFS_CTRL_SEVEN: st_d.c7 = wr_data_in;
        ccr_pkg::OFS_CTRL_ONE:   st_d.c1 = wr_data_in;
        ccr_pkg::OFS_CTRL_TWO:   st_d.c2 = wr_data_in;
        ccr_pkg::OFS_CTRL_THREE: begin
          // A digital reset discards the rest of the written word
          if (wr_data_in[ccr_pkg::C3_DIG_RST]) begin
            st_d.c7       = ccr_pkg::RST_CTRL_SEVEN;
            st_d.c1       = ccr_pkg::RST_CTRL_ONE;
            st_d.c2       = ccr_pkg::RST_CTRL_TWO;
            st_d.c3       = ccr_pkg::RST_CTRL_THREE;
            st_d.c4       = ccr_pkg::RST_CTRL_FOUR;
            st_d.latched  = 1'b0;
            st_d.resample = 1'b1;
          end else begin
            st_d.c3 = wr_data_in;
          end
        end
        ccr_pkg::OFS_CTRL_FOUR: begin
          st_d.c4 = wr_data_in;
          st_d.c4[ccr_pkg::C4_CLR] = 1'b0;
        end
        default: begin
          // Unmapped command: write ignored
        end
      endcase
    end

    // Read data captured on the strobe; unmapped reads give zero
    // Read data then stands until the next read strobe
    if (rd_en_in) begin
      case (cmd_in)
        ccr_pkg::OFS_CTRL_SEVEN: st_d.rd_data = st_q.c7;
        ccr_pkg::OFS_CTRL_ONE:   st_d.rd_data = st_q.c1;
        ccr_pkg::OFS_CTRL_TWO:   st_d.rd_data = st_q.c2;
        ccr_pkg::OFS_CTRL_THREE: st_d.rd_data = st_q.c3;
        ccr_pkg::OFS_CTRL_FOUR:  st_d.rd_data = st_q.c4;
        default:                 st_d.rd_data = 16'h0000;
      endcase
    end
  end

  //============================================================================
  // State register
  // Reset loads each word's power-on default; all else starts at zero
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q    <= '0;
      st_q.c7 <= ccr_pkg::RST_CTRL_SEVEN;
      st_q.c1 <= ccr_pkg::RST_CTRL_ONE;
      st_q.c2 <= ccr_pkg::RST_CTRL_TWO;
      st_q.c3 <= ccr_pkg::RST_CTRL_THREE;
      st_q.c4 <= ccr_pkg::RST_CTRL_FOUR;
    end else begin
      st_q <= st_d;
    end
  end

  //============================================================================
  // Outputs
  // Outputs come straight from registered state, except the ADC,
  // battery-absent and interrupt-drive terms, which follow their pins without delay
  always_comb begin
    rd_data_out       = st_q.rd_data;
    // Open drain: only ever pulls low
    alarm_o_out       = 1'b0;
    alarm_oe_out      = st_q.active;
    if (st_q.c2[ccr_pkg::C2_CMP_DIS]) begin
      shared_o_out    = 1'b0;
      shared_oe_out   = int_req_in;
    end else begin
      shared_o_out    = st_q.cmp_prev;
      shared_oe_out   = 1'b1;
    end
    fault_out         = flt;
    adc_enable_out    = st_q.c3[ccr_pkg::C3_ADC_ALL] |
                        (adapter_present_in & charging_in);
    bat_absent_out    = bat_abs;
    limit_reload_out  = st_q.reload;
    resample_req_out  = st_q.resample;
    cfg_out.mon_battery   = st_q.c1[ccr_pkg::C1_MON_SEL];
    cfg_out.vsys_lo_code  = st_q.c1[ccr_pkg::C1_VLO_LSB +: 3];
    cfg_out.trickle_code  = st_q.c2[ccr_pkg::C2_TRKL_LSB +: 3];
    cfg_out.therm_profile = {st_q.c2[ccr_pkg::C2_PROF_HI],
                             st_q.c4[ccr_pkg::C4_PROF_LO]};
    cfg_out.therm_src_on  = st_q.c2[ccr_pkg::C2_PROF_HI] |
                            st_q.c4[ccr_pkg::C4_PROF_LO];
    cfg_out.timeout_code  = st_q.c3[ccr_pkg::C3_TMO_LSB +: 2];
    cfg_out.term_long     = st_q.c3[ccr_pkg::C3_TERM_LONG];
    cfg_out.auto_charge   = st_q.c3[ccr_pkg::C3_AUTO_CHG];
    cfg_out.eoc_code      = st_q.c7[ccr_pkg::C7_EOC_LSB +: 2];
    cfg_out.two_level     = st_q.c2[ccr_pkg::C2_TWO_LVL];
    cfg_out.t1_us = cfg_out.two_level ?
                    dur_us(st_q.c7[ccr_pkg::C7_T1_LSB +: 3]) : 15'h0000;
    cfg_out.t2_us = cfg_out.two_level ?
                    t2_us(st_q.c7[ccr_pkg::C7_T2_LSB +: 3]) : 14'h0000;
  end

endmodule

// ### tb/ccr_bank_assertions.sv
`timescale 1ns/10ps
// ====
// Port checks: strobes, idle bits, alarm hold
module ccr_bank_chk (
  input wire logic        ref_clk_in,         // Clock
  input wire logic        rst_b_in,           // Reset, active low
  input wire logic [7:0]  cmd_in,             // Command code
  input wire logic        wr_en_in,           // Write strobe
  input wire logic [15:0] wr_data_in,         // Write data
  input wire logic        rd_en_in,           // Read strobe
  input wire logic [15:0] rd_data_out,        // Read data
  input wire logic        adapter_present_in, // Adapter
  input wire logic        battery_absent_in,  // Battery pin
  input wire logic        charging_in,        // Charging
  input wire logic        alarm_o_out,        // Alarm value
  input wire logic        alarm_oe_out,       // Alarm drive
  input wire logic        adc_enable_out,     // ADC on
  input wire logic        bat_absent_out,     // Battery used
  input wire logic        limit_reload_out,   // Reload pulse
  input wire logic        resample_req_out,   // Resample pulse
  input ccr_pkg::ccr_cfg_type cfg_out         // Fields
);
  // ====
  // All checks share one clock and reset
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  chk_alarm_open_drain: assert property (alarm_o_out == 1'b0)
    else $error("alarm pin value not low");
  chk_alarm_min_hold: assert property (
    $rose(alarm_oe_out) |-> alarm_oe_out[*8])
    else $error("alarm dropped too soon");
  chk_reload_after_fall: assert property (
    limit_reload_out |-> !$past(adapter_present_in))
    else $error("reload without adapter loss");
  chk_reload_one_shot: assert property (
    limit_reload_out |=> !limit_reload_out) else $error("reload long");
  chk_resample_cause: assert property (
    wr_en_in && cmd_in == 8'h4c && wr_data_in[2] |-> ##[1:2]
    resample_req_out) else $error("no resample after reset");
  chk_resample_one_shot: assert property (
    resample_req_out |=> !resample_req_out) else $error("resample long");
  chk_reset_bit_idle: assert property (
    rd_en_in && cmd_in == 8'h4c |=> !rd_data_out[2])
    else $error("reset bit reads one");
  chk_clear_bit_idle: assert property (
    rd_en_in && cmd_in == 8'h4e |=> !rd_data_out[1])
    else $error("clear bit reads one");
  chk_adc_charging: assert property (
    adapter_present_in && charging_in |-> adc_enable_out)
    else $error("adc off while charging");
  chk_batt_ignore: assert property (
    bat_absent_out |-> battery_absent_in) else $error("battery flag");
  chk_profile_source: assert property (
    cfg_out.therm_src_on == (cfg_out.therm_profile != 2'h0))
    else $error("thermistor source mismatch");
endmodule

// ### tb/ccr_host_model.sv
`timescale 1ns/10ps
// ====
// Bus host: whole-word writes and reads
module ccr_host_model (
  input  wire logic        clk_in,     // Clock
  input  wire logic [15:0] rd_data_in, // Read data
  output logic      [7:0]  cmd_out,    // Command code
  output logic             wr_out,     // Write strobe
  output logic      [15:0] wd_out,     // Write data
  output logic             rd_out      // Read strobe
);
  // Idle bus; released lines show inverse so stale data never matches
  initial begin
    {cmd_out, wr_out, wd_out, rd_out} = '0;
  end
  task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    {cmd_out, wd_out, wr_out} = {c, d, 1'b1};
    @(negedge clk_in);
    {cmd_out, wd_out, wr_out} = {~c, ~d, 1'b0};
  endtask
  task automatic rd_word(input logic [7:0] c, output logic [15:0] d);
    @(negedge clk_in);
    {cmd_out, rd_out} = {c, 1'b1};
    @(negedge clk_in);
    {cmd_out, rd_out} = {~c, 1'b0};
    d = rd_data_in;
  endtask
endmodule

// ### tb/ccr_bank_test.sv
`timescale 1ns/10ps
`define CHK(n,e,a) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
bind ccr_bank ccr_bank_chk chk_u (.*);
// ====
// Register bank bench
module ccr_bank_test;
  logic ref_clk_in, rst_b_in, wr, rd, ap, ba, chg, sup, acdc, lvs;
  logic rov, cmp, hot, oc, tmr, oth, irq, ao, aoe, so, soe, flt, adc;
  logic bao, rld, rsm;
  logic [7:0] cmd;
  logic [15:0] wd, rdat, v;
  int mismatches, comparisons, npulse;
  ccr_pkg::ccr_cfg_type cfg;
  ccr_host_model h (.clk_in(ref_clk_in), .rd_data_in(rdat),
    .cmd_out(cmd), .wr_out(wr), .wd_out(wd), .rd_out(rd));
  // Short tick keeps microsecond figures at two cycles each
  ccr_bank #(.TICK_CYC(2)) dut_u (.ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in), .cmd_in(cmd), .wr_en_in(wr), .wr_data_in(wd),
    .rd_en_in(rd), .rd_data_out(rdat), .adapter_present_in(ap),
    .battery_absent_in(ba), .charging_in(chg), .supplemental_in(sup),
    .ac_dc_alarm_in(acdc), .low_vsys_in(lvs), .rev_ovc_in(rov),
    .cmp_above_in(cmp), .overtemp_in(hot), .overcurrent_in(oc),
    .charge_timer_exp_in(tmr), .other_fault_in(oth), .int_req_in(irq),
    .alarm_o_out(ao), .alarm_oe_out(aoe), .shared_o_out(so),
    .shared_oe_out(soe), .fault_out(flt), .adc_enable_out(adc),
    .bat_absent_out(bao), .limit_reload_out(rld),
    .resample_req_out(rsm), .cfg_out(cfg));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Count reload pulses seen on rising edges
  always @(posedge ref_clk_in) if (rld) npulse++;
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic rchk(input logic [7:0] c, input logic [15:0] e);
    h.rd_word(c, v);
    `CHK("register", e, v)
  endtask
  task automatic defaults;
    rchk(8'h38, 16'h0000);
    rchk(8'h3c, 16'h0003);
    rchk(8'h3d, 16'h6000);
    rchk(8'h4c, 16'h0300);
    rchk(8'h4e, 16'h0000);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    #200000;
    mismatches++;
    end_sim;
  end
  initial begin
    {ap, ba, chg, sup, acdc, lvs, rov, cmp, hot, oc, tmr, oth, irq} = '0;
    rst_b_in = 1'b0;
    wt(3);
    rst_b_in = 1'b1;
    defaults();
    rchk(8'h39, 16'h0000);
    $display("defaults done");
    h.wr_word(8'h3c, 16'h0015);
    h.wr_word(8'h3d, 16'hb024);
    h.wr_word(8'h4e, 16'h4000);
    h.wr_word(8'h38, 16'he600);
    h.wr_word(8'h4c, 16'h3b80);
    rchk(8'h3d, 16'hb024);
    `CHK("mon", 1'b1, cfg.mon_battery)
    `CHK("vlo", 3'h5, cfg.vsys_lo_code)
    `CHK("trickle", 3'h5, cfg.trickle_code)
    `CHK("profile", 2'h3, cfg.therm_profile)
    `CHK("timeout", 2'h3, cfg.timeout_code)
    `CHK("term", 1'b1, cfg.term_long)
    `CHK("eoc", 2'h2, cfg.eoc_code)
    `CHK("t1", 15'h4e20, cfg.t1_us)
    `CHK("t2", 14'h2710, cfg.t2_us)
    `CHK("auto", 1'b1, cfg.auto_charge)
    // Inverted polarity: above reference drives low
    cmp = 1'b1;
    wt(3);
    `CHK("cmp_o", 1'b0, so)
    `CHK("cmp_oe", 1'b1, soe)
    cmp = 1'b0;
    tmr = 1'b1;
    wt(3);
    tmr = 1'b0;
    `CHK("cmp_o", 1'b1, so)
    `CHK("auto", 1'b0, cfg.auto_charge)
    h.wr_word(8'h3d, 16'hb02c);
    irq = 1'b1;
    wt(3);
    `CHK("int_oe", 1'b1, soe)
    `CHK("int_o", 1'b0, so)
    irq = 1'b0;
    wt(3);
    `CHK("int_oe", 1'b0, soe)
    $display("fields done");
    `CHK("adc", 1'b0, adc)
    {ap, chg, ba} = 3'b111;
    wt(1);
    `CHK("adc", 1'b1, adc)
    `CHK("batt", 1'b1, bao)
    chg = 1'b0;
    h.wr_word(8'h4e, 16'h8000);
    h.wr_word(8'h4c, 16'h0301);
    `CHK("batt", 1'b0, bao)
    `CHK("adc", 1'b1, adc)
    npulse = 0;
    ap = 1'b0;
    wt(4);
    `CHK("reload", 1, npulse)
    h.wr_word(8'h4c, 16'h4300);
    ap = 1'b1;
    wt(2);
    npulse = 0;
    ap = 1'b0;
    wt(4);
    `CHK("reload", 0, npulse)
    $display("pins done");
    h.wr_word(8'h4c, 16'h0004);
    defaults();
    $display("digital reset done");
    h.wr_word(8'h3d, 16'h6180);
    acdc = 1'b1;
    wt(8);
    `CHK("deb", 1'b0, aoe)
    wt(14);
    `CHK("deb", 1'b1, aoe)
    acdc = 1'b0;
    wt(400);
    h.wr_word(8'h4e, 16'h0011);
    cmp = 1'b1;
    wt(3);
    `CHK("trip", 1'b1, aoe)
    cmp = 1'b0;
    wt(400);
    `CHK("latch", 1'b1, aoe)
    h.wr_word(8'h4e, 16'h0013);
    wt(3);
    `CHK("clear", 1'b0, aoe)
    rchk(8'h4e, 16'h0011);
    h.wr_word(8'h4e, 16'h0010);
    cmp = 1'b1;
    wt(3);
    cmp = 1'b0;
    wt(100);
    `CHK("hold", 1'b1, aoe)
    wt(300);
    `CHK("auto clr", 1'b0, aoe)
    // Supplemental low voltage trips in 2us, far before the 7us setting
    {sup, lvs, hot} = 3'b111;
    wt(8);
    `CHK("sup deb", 1'b1, aoe)
    `CHK("fault", 1'b0, flt)
    {sup, lvs, hot} = 3'b000;
    $display("alarm done");
    end_sim;
  end
endmodule
